// ==== hw/rftx_defs.svh ====
`ifndef RFTX_DEFS_SVH
`define RFTX_DEFS_SVH

// Register indices
`define RFTX_A_TXDATA  4'h0
`define RFTX_A_ENC     4'h1
`define RFTX_A_CTRL    4'h2
`define RFTX_A_STATUS  4'h3
`define RFTX_A_DIVINT  4'h4
`define RFTX_A_DIVFRAC 4'h5
`define RFTX_A_FREQ_DEVIATION    4'h6
`define RFTX_A_GAUSS   4'h7
`define RFTX_A_BAUD    4'h8
`define RFTX_A_RAMP    4'h9
`define RFTX_A_SUPPLY  4'ha
`define RFTX_A_ASK     4'hb
`define RFTX_A_STARTUP 4'hc

// Encoder config fields
`define RFTX_ENC_SCHEME 2:0
`define RFTX_ENC_NBITS  6:4
`define RFTX_ENC_IDLE   7
`define RFTX_ENC_INV    8

// Control fields
`define RFTX_CTL_AMPEN  0
`define RFTX_CTL_PLLMON 1
`define RFTX_CTL_XMON   2
`define RFTX_CTL_FSM    3
`define RFTX_CTL_BYPASS 4
`define RFTX_CTL_BOOST  5
`define RFTX_CTL_ASK    6

// Status: write one clears the shutoff flag
`define RFTX_ST_SHUTOFF 4

// ASK fields
`define RFTX_ASK_HI    7:0
`define RFTX_ASK_LO    15:8
`define RFTX_ASK_SLOPE 23:16
`define RFTX_ASK_RATE  27:24

// Encoding schemes
`define RFTX_SCH_MAN   3'h0
`define RFTX_SCH_IMAN  3'h1
`define RFTX_SCH_DMAN  3'h2
`define RFTX_SCH_BI0   3'h3
`define RFTX_SCH_BI1   3'h4
`define RFTX_SCH_CHIP  3'h5

// Reset value and deviation multiplier
`define RFTX_RST_NBITS 3'h7
`define RFTX_FREQ_DEVIATION_MULT 15'h005f

`endif

// ==== hw/rftx_pkg.sv ====
package rftx_pkg;

    typedef enum logic [1:0] {RFTX_IDLE, RFTX_WAIT, RFTX_SEND} rftx_phase_type;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [31:0] wdata;
    } rftx_bus_type;

    typedef struct packed {
        rftx_phase_type phase;
        logic [7:0]  tx_byte;
        logic        full;
        logic [7:0]  shreg;
        logic [2:0]  bits_left;
        logic        half;
        logic        line;
        logic [17:0] chip_cnt;
        logic [15:0] wait_cnt;
        logic        empty;
        logic        shutoff;
        logic [31:0] rdata;
        logic [2:0]  scheme;
        logic [2:0]  nbits;
        logic        idle_lvl;
        logic        invert;
        logic        amp_en;
        logic        pll_mon;
        logic        xtal_mon;
        logic        fsm_mode;
        logic        bypass;
        logic        boost;
        logic        ask_mode;
        logic [7:0]  div_int;
        logic [20:0] div_frac;
        logic [7:0]  freq_deviation;
        logic [11:0] gdiv;
        logic [11:0] g_cnt;
        logic        g_tick;
        logic [15:0] baud_divider;
        logic [7:0]  fsk_ramp_duration;
        logic [7:0]  ramp;
        logic [7:0]  supply_lvl;
        logic [7:0]  ask_hi;
        logic [7:0]  ask_lo;
        logic [7:0]  slope;
        logic [3:0]  ratediv;
        logic [3:0]  rate_acc;
        logic [7:0]  supply;
        logic [15:0] startup;
        logic [22:0] sd_acc;
        logic [7:0]  ratio;
        logic        amp_on;
        logic        enc_out;
    } rftx_state_type;

endpackage : rftx_pkg

// ==== hw/rftx_ctrl.sv ====
// The register addresses and the address-and-strobe port were chosen for this implementation.
`include "rftx_defs.svh"

// Function
// R1 - With amp enabled, idle bit sets idle level
// R2 - Amp enable clear: amp off after transmission
// R3 - Invert bit inverts encoder output
// R4 - Length field plus one bits, MSB first
// R5 - Buffer full flag; no writes while set
// R6 - Shift empty flag when byte finished
// R7 - Monitors kill amp on unlock or crystal fail
// R8 - Amp shutoff flag set on monitor kill
// R9 - Monitors off after reset
// R10 - Center frequency from integer and fraction
// R11 - Data line selects FSK high or low
// R12 - Deviation offset is freq_deviation times 95 over 2^23
// R13 - Gaussian sample divider, 12 bits
// R14 - Controller mode switches amp automatically
// R15 - Bypass bit selects unregulated amp supply
// R16 - FSK amp ramp time from ramp field
// R17 - FSK/OOK constant supply, ASK trapezoid
// R18 - ASK low and high supply levels
// R19 - ASK ramp slope plus fractional rate
// R20 - Crystal boost off after reset
// R21 - Wait crystal start-up before sending; code waits only in controller mode
// R22 - Scheme field selects six encodings
// R23 - Encoding starts on byte write, MSB first
// R24 - Chip period is four baud divider steps
// R25 - Accumulator steps once per reference cycle
module rftx_ctrl (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    // Register port
    input  wire rftx_pkg::rftx_bus_type bus,
    output logic [31:0]                rdata,
    // Monitors
    input  wire logic                  pll_unlock_flag,
    input  wire logic                  xtal_fail_flag,
    input  wire logic                  xtal_stable,
    // Modulator and amplifier
    output logic                       tx_line,
    output logic                       amp_on,
    output logic [7:0]                 amp_ramp,
    output logic [7:0]                 amp_supply_pin,
    output logic [7:0]                 divider_ratio,
    output logic                       gauss_tick,
    output logic                       reg_bypass,
    output logic                       xtal_boost,
    // Status
    output logic                       tx_buffer_full,
    output logic                       shift_empty,
    output logic                       amp_shutoff_flag
);

    rftx_pkg::rftx_state_type s_q;
    rftx_pkg::rftx_state_type s_d;

    // Level of the first chip of a bit
    function automatic logic first_half(input logic [2:0] sch, input logic b,
                                        input logic prev);
        case (sch)
            `RFTX_SCH_IMAN: first_half = ~b;
            `RFTX_SCH_DMAN: first_half = b ? prev : ~prev;
            `RFTX_SCH_BI0,
            `RFTX_SCH_BI1:  first_half = ~prev;
            default:        first_half = b;
        endcase
    endfunction : first_half

    // Level of the second chip of a bit
    function automatic logic second_half(input logic [2:0] sch, input logic b,
                                         input logic first);
        case (sch)
            `RFTX_SCH_BI0: second_half = b ? first : ~first;
            `RFTX_SCH_BI1: second_half = b ? ~first : first;
            default:       second_half = ~first;
        endcase
    endfunction : second_half

    logic        chip_tick;
    logic        bit_end;
    logic        fault;
    logic        amp_req;
    logic [14:0] dev;
    logic [31:0] base;
    logic [31:0] total;
    logic [23:0] sd_sum;
    logic [4:0]  rate_sum;
    logic [8:0]  step;
    logic [8:0]  up;
    logic [8:0]  dn;
    logic [7:0]  target;

    always_comb begin
        s_d       = s_q;
        s_d.rdata = 32'h0000_0000;
        s_d.g_tick = 1'b0;

        // Register writes
        if (bus.wr) begin
            if (bus.addr == `RFTX_A_TXDATA) begin
                if (!s_q.full) begin
                    s_d.tx_byte = bus.wdata[7:0];
                    s_d.full    = 1'b1; // R5
                end
            end else if (bus.addr == `RFTX_A_ENC) begin
                s_d.scheme   = bus.wdata[`RFTX_ENC_SCHEME];
                s_d.nbits    = bus.wdata[`RFTX_ENC_NBITS];
                s_d.idle_lvl = bus.wdata[`RFTX_ENC_IDLE];
                s_d.invert   = bus.wdata[`RFTX_ENC_INV];
            end else if (bus.addr == `RFTX_A_CTRL) begin
                s_d.amp_en   = bus.wdata[`RFTX_CTL_AMPEN];
                s_d.pll_mon  = bus.wdata[`RFTX_CTL_PLLMON];
                s_d.xtal_mon = bus.wdata[`RFTX_CTL_XMON];
                s_d.fsm_mode = bus.wdata[`RFTX_CTL_FSM];
                s_d.bypass   = bus.wdata[`RFTX_CTL_BYPASS]; // R15
                s_d.boost    = bus.wdata[`RFTX_CTL_BOOST]; // R20
                s_d.ask_mode = bus.wdata[`RFTX_CTL_ASK];
            end else if (bus.addr == `RFTX_A_STATUS) begin
                if (bus.wdata[`RFTX_ST_SHUTOFF]) begin
                    s_d.shutoff = 1'b0;
                end
            end else if (bus.addr == `RFTX_A_DIVINT) begin
                s_d.div_int = bus.wdata[7:0];
            end else if (bus.addr == `RFTX_A_DIVFRAC) begin
                s_d.div_frac = bus.wdata[20:0];
            end else if (bus.addr == `RFTX_A_FREQ_DEVIATION) begin
                s_d.freq_deviation = bus.wdata[7:0];
            end else if (bus.addr == `RFTX_A_GAUSS) begin
                s_d.gdiv = bus.wdata[11:0];
            end else if (bus.addr == `RFTX_A_BAUD) begin
                s_d.baud_divider = bus.wdata[15:0];
            end else if (bus.addr == `RFTX_A_RAMP) begin
                s_d.fsk_ramp_duration = bus.wdata[7:0];
            end else if (bus.addr == `RFTX_A_SUPPLY) begin
                s_d.supply_lvl = bus.wdata[7:0];
            end else if (bus.addr == `RFTX_A_ASK) begin
                s_d.ask_hi  = bus.wdata[`RFTX_ASK_HI];
                s_d.ask_lo  = bus.wdata[`RFTX_ASK_LO];
                s_d.slope   = bus.wdata[`RFTX_ASK_SLOPE];
                s_d.ratediv = bus.wdata[`RFTX_ASK_RATE];
            end else if (bus.addr == `RFTX_A_STARTUP) begin
                s_d.startup = bus.wdata[15:0];
            end
        end

        // Register reads, data valid next cycle
        if (bus.rd) begin
            if (bus.addr == `RFTX_A_TXDATA) begin
                s_d.rdata = {24'h000000, s_q.tx_byte};
            end else if (bus.addr == `RFTX_A_ENC) begin
                s_d.rdata = {23'h000000, s_q.invert, s_q.idle_lvl, s_q.nbits,
                             1'b0, s_q.scheme};
            end else if (bus.addr == `RFTX_A_CTRL) begin
                s_d.rdata = {25'h0000000, s_q.ask_mode, s_q.boost, s_q.bypass,
                             s_q.fsm_mode, s_q.xtal_mon, s_q.pll_mon, s_q.amp_en};
            end else if (bus.addr == `RFTX_A_STATUS) begin
                s_d.rdata = {26'h0000000, xtal_stable, s_q.shutoff, xtal_fail_flag,
                             pll_unlock_flag, s_q.empty, s_q.full};
            end else if (bus.addr == `RFTX_A_DIVINT) begin
                s_d.rdata = {24'h000000, s_q.div_int};
            end else if (bus.addr == `RFTX_A_DIVFRAC) begin
                s_d.rdata = {11'h000, s_q.div_frac};
            end else if (bus.addr == `RFTX_A_FREQ_DEVIATION) begin
                s_d.rdata = {24'h000000, s_q.freq_deviation};
            end else if (bus.addr == `RFTX_A_GAUSS) begin
                s_d.rdata = {20'h00000, s_q.gdiv};
            end else if (bus.addr == `RFTX_A_BAUD) begin
                s_d.rdata = {16'h0000, s_q.baud_divider};
            end else if (bus.addr == `RFTX_A_RAMP) begin
                s_d.rdata = {24'h000000, s_q.fsk_ramp_duration};
            end else if (bus.addr == `RFTX_A_SUPPLY) begin
                s_d.rdata = {24'h000000, s_q.supply_lvl};
            end else if (bus.addr == `RFTX_A_ASK) begin
                s_d.rdata = {4'h0, s_q.ratediv, s_q.slope, s_q.ask_lo, s_q.ask_hi};
            end else if (bus.addr == `RFTX_A_STARTUP) begin
                s_d.rdata = {16'h0000, s_q.startup};
            end
        end

        // Chip timer: 4*(divider+1) clocks per chip
        chip_tick = (s_q.phase == rftx_pkg::RFTX_SEND) &&
                    (s_q.chip_cnt == {s_q.baud_divider, 2'b11}); // R24
        bit_end   = (s_q.scheme == `RFTX_SCH_CHIP) || s_q.half; // R22
        if (s_q.phase != rftx_pkg::RFTX_SEND || chip_tick) begin
            s_d.chip_cnt = 18'h00000;
        end else begin
            s_d.chip_cnt = s_q.chip_cnt + 18'h00001;
        end

        // Byte sequencer
        case (s_q.phase)
            rftx_pkg::RFTX_IDLE: begin
                if (s_q.full) begin
                    s_d.shreg     = s_q.tx_byte; // R23
                    s_d.full      = 1'b0;
                    s_d.bits_left = s_q.nbits; // R4
                    s_d.half      = 1'b0;
                    s_d.empty     = 1'b0;
                    s_d.line      = first_half(s_q.scheme, s_q.tx_byte[7], s_q.line);
                    if (s_q.fsm_mode && !s_q.amp_on) begin
                        s_d.phase    = rftx_pkg::RFTX_WAIT;
                        s_d.wait_cnt = s_q.startup; // R21
                    end else begin
                        s_d.phase = rftx_pkg::RFTX_SEND;
                    end
                end
            end
            rftx_pkg::RFTX_WAIT: begin
                if (s_q.wait_cnt == 16'h0000) begin
                    s_d.phase = rftx_pkg::RFTX_SEND; // R21
                end else begin
                    s_d.wait_cnt = s_q.wait_cnt - 16'h0001;
                end
            end
            rftx_pkg::RFTX_SEND: begin
                if (chip_tick) begin
                    if (!bit_end) begin
                        s_d.half = 1'b1;
                        s_d.line = second_half(s_q.scheme, s_q.shreg[7], s_q.line);
                    end else if (s_q.bits_left != 3'h0) begin
                        s_d.shreg     = {s_q.shreg[6:0], 1'b0};
                        s_d.bits_left = s_q.bits_left - 3'h1; // R4
                        s_d.half      = 1'b0;
                        s_d.line      = first_half(s_q.scheme, s_q.shreg[6], s_q.line);
                    end else if (s_q.full) begin
                        // Back-to-back byte keeps the stream gapless
                        s_d.shreg     = s_q.tx_byte;
                        s_d.full      = 1'b0;
                        s_d.bits_left = s_q.nbits;
                        s_d.half      = 1'b0;
                        s_d.line      = first_half(s_q.scheme, s_q.tx_byte[7], s_q.line);
                    end else begin
                        s_d.phase = rftx_pkg::RFTX_IDLE;
                        s_d.empty = 1'b1; // R6
                    end
                end
            end
            default: begin
                s_d.phase = rftx_pkg::RFTX_IDLE;
            end
        endcase

        // Encoder output with idle level and inversion
        if (s_d.phase == rftx_pkg::RFTX_SEND) begin
            s_d.enc_out = s_d.line ^ s_d.invert; // R3
        end else begin
            s_d.enc_out = s_d.idle_lvl ^ s_d.invert; // R1
        end

        // Amplifier switching and monitors
        fault   = (s_q.pll_mon && pll_unlock_flag) || (s_q.xtal_mon && xtal_fail_flag);
        amp_req = (s_d.phase == rftx_pkg::RFTX_SEND) ||
                  (s_d.amp_en && !s_d.fsm_mode); // R2 R14
        if (fault && s_q.amp_on) begin
            s_d.shutoff = 1'b1; // R8
        end
        // Shutoff stays until cleared so the amp cannot chatter back on
        s_d.amp_on = amp_req && !fault && !s_d.shutoff; // R7

        // FSK impedance ramp
        if (s_q.ask_mode) begin
            s_d.ramp = s_q.amp_on ? s_q.fsk_ramp_duration : 8'h00;
        end else if (s_q.amp_on && s_q.ramp < s_q.fsk_ramp_duration) begin
            s_d.ramp = s_q.ramp + 8'h01; // R16
        end else if (!s_q.amp_on && s_q.ramp != 8'h00) begin
            s_d.ramp = s_q.ramp - 8'h01; // R16
        end else if (s_q.ramp > s_q.fsk_ramp_duration) begin
            s_d.ramp = s_q.fsk_ramp_duration;
        end

        // Supply level: constant or ASK trapezoid
        rate_sum   = {1'b0, s_q.rate_acc} + {1'b0, s_q.ratediv} + 5'h01; // R19
        s_d.rate_acc = rate_sum[3:0];
        step       = {1'b0, s_q.slope} + {8'h00, rate_sum[4]};
        target     = (s_q.amp_on && s_q.enc_out) ? s_q.ask_hi : s_q.ask_lo; // R18
        up         = {1'b0, s_q.supply} + step;
        dn         = {1'b0, s_q.supply} - step;
        if (!s_d.ask_mode) begin
            s_d.supply = s_d.amp_on ? s_d.supply_lvl : 8'h00; // R17
        end else if (s_q.supply < target) begin
            s_d.supply = (up > {1'b0, target}) ? target : up[7:0]; // R19
        end else if (s_q.supply > target) begin
            s_d.supply = (dn[8] || dn < {1'b0, target}) ? target : dn[7:0]; // R19
        end

        // Sigma-delta divider, fraction kept in 2^-23 units
        dev   = {7'h00, s_q.freq_deviation} * `RFTX_FREQ_DEVIATION_MULT; // R12
        base  = {1'b0, s_q.div_int, s_q.div_frac, 2'b00}; // R10
        if (s_q.ask_mode) begin
            total = base;
        end else if (s_q.enc_out) begin
            total = base + {17'h00000, dev}; // R11
        end else begin
            total = base - {17'h00000, dev}; // R11
        end
        sd_sum     = {1'b0, s_q.sd_acc} + {1'b0, total[22:0]}; // R25
        s_d.sd_acc = sd_sum[22:0];
        s_d.ratio  = total[30:23] + {7'h00, sd_sum[23]}; // R25

        // Gaussian filter sample clock
        if (s_q.g_cnt >= s_q.gdiv) begin
            s_d.g_cnt  = 12'h000;
            s_d.g_tick = 1'b1; // R13
        end else begin
            s_d.g_cnt = s_q.g_cnt + 12'h001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q          <= '0;
            s_q.phase    <= rftx_pkg::RFTX_IDLE;
            s_q.nbits    <= `RFTX_RST_NBITS; // R4
            s_q.empty    <= 1'b1;
            s_q.pll_mon  <= 1'b0; // R9
            s_q.xtal_mon <= 1'b0; // R9
            s_q.boost    <= 1'b0; // R20
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata            = s_q.rdata;
    assign tx_line          = s_q.enc_out;
    assign amp_on           = s_q.amp_on;
    assign amp_ramp         = s_q.ramp;
    assign amp_supply_pin   = s_q.supply;
    assign divider_ratio    = s_q.ratio;
    assign gauss_tick       = s_q.g_tick;
    assign reg_bypass       = s_q.bypass;
    assign xtal_boost       = s_q.boost;
    assign tx_buffer_full   = s_q.full;
    assign shift_empty      = s_q.empty;
    assign amp_shutoff_flag = s_q.shutoff;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    property p_idle_level;
        (s_q.phase == rftx_pkg::RFTX_IDLE)[*2] |-> tx_line == (s_q.idle_lvl ^ s_q.invert);
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("idle level wrong"); // R1

    property p_full_set;
        bus.wr && bus.addr == `RFTX_A_TXDATA && !s_q.full &&
        s_q.phase == rftx_pkg::RFTX_SEND && !chip_tick |=> tx_buffer_full;
    endproperty
    a_full_set: assert property (p_full_set) else $error("full flag not set"); // R5

    property p_empty;
        s_q.phase == rftx_pkg::RFTX_SEND ##1 s_q.phase == rftx_pkg::RFTX_IDLE
        |-> shift_empty;
    endproperty
    a_empty: assert property (p_empty) else $error("shift empty missing"); // R6

    property p_kill;
        fault && amp_on |=> !amp_on && amp_shutoff_flag;
    endproperty
    a_kill: assert property (p_kill) else $error("amp not killed"); // R7

    property p_flag_hold;
        amp_shutoff_flag && !(bus.wr && bus.addr == `RFTX_A_STATUS) |=> amp_shutoff_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("shutoff flag lost"); // R8

    property p_mon_reset;
        $fell(rst) |-> !s_q.pll_mon && !s_q.xtal_mon && !xtal_boost;
    endproperty
    a_mon_reset: assert property (p_mon_reset) else $error("monitor not off"); // R9

    property p_chip_bound;
        s_q.chip_cnt <= {s_q.baud_divider, 2'b11};
    endproperty
    a_chip_bound: assert property (p_chip_bound) else $error("chip timer overrun"); // R24

    property p_const_supply;
        !s_q.ask_mode && amp_on |-> amp_supply_pin == s_q.supply_lvl;
    endproperty
    a_const_supply: assert property (p_const_supply) else $error("supply wrong"); // R17

    property p_wait;
        s_q.phase == rftx_pkg::RFTX_WAIT && s_q.wait_cnt != 16'h0000
        |=> s_q.phase == rftx_pkg::RFTX_WAIT && !amp_on;
    endproperty
    a_wait: assert property (p_wait) else $error("start-up wait cut"); // R21

    property p_fsm_off;
        s_q.fsm_mode && s_q.phase != rftx_pkg::RFTX_SEND |-> !amp_on;
    endproperty
    a_fsm_off: assert property (p_fsm_off) else $error("amp on while idle"); // R14

    c_send: cover property (s_q.phase == rftx_pkg::RFTX_SEND ##1 shift_empty);
    c_kill: cover property (amp_on ##1 amp_shutoff_flag);
    c_ask:  cover property (s_q.ask_mode && amp_on && amp_supply_pin == s_q.ask_hi);

endmodule : rftx_ctrl

// ==== testbench/rftx_host_model.sv ====
// Stands in for the CPU or the transmission controller on the register port
module rftx_host_model (
    // Clock
    input  wire logic                   core_clk,
    // Register port
    output rftx_pkg::rftx_bus_type      bus,
    input  wire logic [31:0]            rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    initial bus = '0;

    // Released address and data show the inverse, never a stale copy
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge core_clk);
        bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 32'hffffffff};
        #1 d = rdata;
    endtask : rd_reg
endmodule : rftx_host_model

// ==== testbench/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic                   core_clk = 1'b0;
    logic                   rst = 1'b1;
    logic                   pll_unlock_flag = 1'b0;
    logic                   xtal_fail_flag = 1'b0;
    logic                   xtal_stable = 1'b0;
    rftx_pkg::rftx_bus_type bus;
    logic [31:0]            rdata;
    logic                   tx_line;
    logic                   amp_on;
    logic [7:0]             amp_ramp;
    logic [7:0]             amp_supply_pin;
    logic [7:0]             divider_ratio;
    logic                   gauss_tick;
    logic                   reg_bypass;
    logic                   xtal_boost;
    logic                   tx_buffer_full;
    logic                   shift_empty;
    logic                   amp_shutoff_flag;
    int                     num_errors = 0;
    int                     n_checks = 0;

    always #20 core_clk = ~core_clk;

    rftx_ctrl DUT (.core_clk, .rst, .bus, .rdata, .pll_unlock_flag, .xtal_fail_flag,
        .xtal_stable, .tx_line, .amp_on, .amp_ramp, .amp_supply_pin, .divider_ratio,
        .gauss_tick, .reg_bypass, .xtal_boost, .tx_buffer_full, .shift_empty,
        .amp_shutoff_flag);

    rftx_host_model HOST (.core_clk, .bus, .rdata);

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask : check

    // Reset values, one unmapped index among them
    task automatic test_reset;
        logic [31:0] d;
        logic [3:0]  a [4] = '{4'h1, 4'h2, 4'h3, 4'hd};
        logic [31:0] e [4] = '{32'h70, 32'h0, 32'h2, 32'h0};
        for (int i = 0; i < 4; i++) begin
            HOST.rd_reg(a[i], d);
            check("reset read", e[i], d);
        end
        $display("test_reset done");
    endtask : test_reset

    // Chips expected MSB first in chips[7 -: n], one per 4 cycles with baud divider 0
    task automatic tx_check(input logic [31:0] enc, input logic [7:0] b,
                            input logic [7:0] chips, input int n, input logic idle);
        HOST.wr_reg(4'h1, enc);
        @(posedge core_clk);
        #1 check("idle level", idle, tx_line);
        HOST.wr_reg(4'h0, {24'h0, b});
        #1 check("buffer full", 1'b1, tx_buffer_full);
        repeat (3) @(posedge core_clk);
        #1 check("shift busy", 1'b0, shift_empty);
        for (int i = 0; i < n; i++) begin
            check("chip", chips[7-i], tx_line);
            repeat (4) @(posedge core_clk);
            #1;
        end
        check("shift empty", 1'b1, shift_empty);
        check("idle after", idle, tx_line);
        $display("tx_check %h done", enc);
    endtask : tx_check

    // Bounded wait for the shifter to drain
    task automatic wait_empty;
        for (int j = 0; j < 60 && shift_empty !== 1'b1; j++) begin
            @(posedge core_clk);
            #1;
        end
        if (shift_empty !== 1'b1) begin
            num_errors++;
            report_and_stop();
        end
    endtask : wait_empty

    // Monitors off ignore a PLL unlock; each enabled monitor kills the amplifier
    task automatic test_monitor;
        logic [31:0] ctl [3] = '{32'h21, 32'h23, 32'h25};
        for (int i = 0; i < 3; i++) begin
            HOST.wr_reg(4'h2, ctl[i]);
            HOST.wr_reg(4'h0, 32'hff);
            repeat (3) @(posedge core_clk);
            #1 check("amp on", 1'b1, amp_on);
            @(posedge core_clk);
            pll_unlock_flag <= (i != 2);
            xtal_fail_flag  <= (i == 2);
            @(posedge core_clk);
            #1 check("amp killed", (i == 0), amp_on);
            check("shutoff flag", (i != 0), amp_shutoff_flag);
            @(posedge core_clk);
            pll_unlock_flag <= 1'b0;
            xtal_fail_flag  <= 1'b0;
            wait_empty();
            HOST.wr_reg(4'h3, 32'h10);
            @(posedge core_clk);
            #1 check("shutoff cleared", 1'b0, amp_shutoff_flag);
        end
        $display("test_monitor done");
    endtask : test_monitor

    // Controller mode: amp waits out crystal start-up, then follows the shifter
    task automatic test_fsm;
        HOST.wr_reg(4'hc, 32'h0a);
        HOST.wr_reg(4'h2, 32'h2e);
        #1 check("fsm amp idle", 1'b0, amp_on);
        HOST.wr_reg(4'h0, 32'h80);
        repeat (11) @(posedge core_clk);
        #1 check("start-up wait", 1'b0, amp_on);
        @(posedge core_clk);
        #1 check("amp on send", 1'b1, amp_on);
        HOST.wr_reg(4'h0, 32'h40);
        #1 check("second byte full", 1'b1, tx_buffer_full);
        wait_empty();
        check("amp off after", 1'b0, amp_on);
        $display("test_fsm done");
    endtask : test_fsm

    // Supply, ramp, divider word, sample tick and pin bits
    task automatic test_analog;
        int n = 0;
        HOST.wr_reg(4'h2, 32'h31);
        HOST.wr_reg(4'h4, 32'h40);
        HOST.wr_reg(4'ha, 32'h33);
        HOST.wr_reg(4'h9, 32'h05);
        HOST.wr_reg(4'h7, 32'h03);
        repeat (8) @(posedge core_clk);
        #1 check("bypass", 1'b1, reg_bypass);
        check("boost", 1'b1, xtal_boost);
        check("ratio", 8'h40, divider_ratio);
        check("supply", 8'h33, amp_supply_pin);
        check("ramp", 8'h05, amp_ramp);
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            #1 n += gauss_tick;
        end
        check("gauss ticks", 2, n);
        HOST.wr_reg(4'h1, 32'h80);
        HOST.wr_reg(4'hb, 32'h0010_0020);
        HOST.wr_reg(4'h2, 32'h71);
        repeat (8) @(posedge core_clk);
        #1 check("ask high", 8'h20, amp_supply_pin);
        $display("test_analog done");
    endtask : test_analog

    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        test_reset();
        HOST.wr_reg(4'h2, 32'h21);
        tx_check(32'hf5, 8'ha5, 8'ha5, 8, 1'b1);
        tx_check(32'h190, 8'h80, 8'h60, 4, 1'b0);
        tx_check(32'h31, 8'h50, 8'h99, 8, 1'b0);
        tx_check(32'h12, 8'h80, 8'ha0, 4, 1'b0);
        tx_check(32'h13, 8'h80, 8'hd0, 4, 1'b0);
        tx_check(32'h14, 8'h80, 8'h40, 4, 1'b0);
        test_monitor();
        test_fsm();
        test_analog();
        report_and_stop();
    end
endmodule : testbench
